// ==== lcm_pkg.sv ====
// Constants shared by the logic cell group design
package lcm_pkg;
   // Group shape
   localparam int NCELL = 10;
   localparam int CFG_W = 22;
   // Cell configuration word fields
   localparam int CFG_LUT_LSB = 0;
   localparam int CFG_MODE_LSB = 16;
   localparam int CFG_CSEL_BIT = 18;
   localparam int CFG_PACK_BIT = 19;
   localparam int CFG_CASC_BIT = 20;
   localparam int CFG_DRV_BIT = 21;
   localparam logic [CFG_W-1:0] CFG_RST = 22'h000000;
   // Mode field codes
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_ARITH = 2'h1;
   localparam logic [1:0] MODE_COUNT = 2'h2;
   // Register word indices (byte address is four times the index)
   localparam logic [5:0] IDX_CFG0 = 6'h00;
   localparam logic [5:0] IDX_QSTAT = 6'h0A;
   localparam logic [5:0] IDX_CSTAT = 6'h0B;
   localparam logic [5:0] IDX_CHAIN = 6'h0C;
   // Reset values
   localparam logic [NCELL-1:0] CELLS_RST = 10'h000;
   localparam logic [31:0] RDATA_RST = 32'h00000000;
   // Mask that makes an arithmetic cell a full adder: carry 0xE8, sum 0x96
   localparam logic [15:0] ADDER_MASK = 16'hE896;
endpackage

// ==== lcm_group.sv ====
// Logic array group of ten configurable logic cells with Avalon-MM setup
// Overview of operation
// R1 - The group holds ten logic cells with carry and cascade chains, shared controls and local routing.
// R2 - Each cell output reaches two local routing areas so one cell can feed up to twenty-nine others.
// R3 - Normal mode feeds a four-input table from the data inputs, with carry-in or input three as one input.
// R4 - In normal mode the table result is combined with cascade-in to form cascade-out along the chain.
// R5 - Normal mode allows the cell register to be used independently of the table result.
// R6 - Arithmetic mode uses two three-input tables on carry-in and inputs one and two, for result and carry-out.
// R7 - As an adder the arithmetic cell gives the sum and carry of inputs one, two and carry-in.
// R8 - Arithmetic mode allows the cascade chain to be used together with the carry chain.
// R9 - An arithmetic cell presents both the registered and the unregistered table result.
// R10 - Counter mode offers clock enable, count enable, up/down, synchronous clear and load.
// R11 - Count enable and up/down come from each cell's data inputs one and two.
// R12 - Synchronous clear and load are group-wide and act on every cell register.
// R13 - A mapping with a counter uses the other cells only in that counter or as pure logic.
// R14 - Each cell drives two separate local routing areas.
// R15 - Clear beats load, load beats counting, and all three wait for the clock enable.
`timescale 1ns/1ps
module lcm_group
   import lcm_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Avalon-MM slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Group-wide controls
   input wire logic grp_clk_en,
   input wire logic grp_sync_clear,
   input wire logic grp_sync_load,
   // Chain entries into cell 0
   input wire logic carry_in,
   input wire logic cascade_in,
   // Per-cell data inputs from local routing
   input wire logic [NCELL-1:0] data_in_one,
   input wire logic [NCELL-1:0] data_in_two,
   input wire logic [NCELL-1:0] data_in_three,
   input wire logic [NCELL-1:0] data_in_four,
   // Cell results
   output logic [NCELL-1:0] cell_q,
   output logic [NCELL-1:0] cell_comb,
   output logic [NCELL-1:0] local_area_a,
   output logic [NCELL-1:0] local_area_b,
   output logic carry_out,
   output logic cascade_out
);

   typedef struct packed {
      logic [NCELL-1:0][CFG_W-1:0] cfg;
      logic [NCELL-1:0] q;
      logic [NCELL-1:0] comb;
      logic [NCELL-1:0] area_a;
      logic [NCELL-1:0] area_b;
      logic carry;
      logic casc;
      logic waitreq;
      logic [31:0] rdata;
   } lcm_state_s;

   lcm_state_s st_r;
   lcm_state_s st_nxt;

   logic [NCELL:0] cin;
   logic [NCELL:0] casc;
   logic [NCELL-1:0] lut_res;
   logic [NCELL-1:0] d_next;

   assign cin[0] = carry_in;
   assign casc[0] = cascade_in;

   // One slice per cell; chains ripple from cell 0 upward
   for (genvar i = 0; i < NCELL; i++) begin : g_cell // R1
      logic [CFG_W-1:0] c;
      logic [1:0] md;
      logic [3:0] idx4;
      logic [2:0] idx3;
      logic l_lut;
      logic l_cout;
      logic l_d;
      assign c = st_r.cfg[i];
      assign md = c[CFG_MODE_LSB +: 2];
      // Table input three is carry-in or data three
      assign idx4 = {data_in_four[i],
                     c[CFG_CSEL_BIT] ? cin[i] : data_in_three[i],
                     data_in_two[i], data_in_one[i]}; // R3
      assign idx3 = {cin[i], data_in_two[i], data_in_one[i]};
      always_comb begin
         l_lut = c[idx4]; // R3
         l_cout = cin[i];
         l_d = l_lut;
         case (md)
            MODE_ARITH: begin
               // Low table gives the result, high table the carry
               l_lut = c[{1'b0, idx3}]; // R6 R7
               l_cout = c[{1'b1, idx3}]; // R6 R7
               l_d = l_lut; // R9
            end
            MODE_COUNT: begin
               // Input one enables, input two selects up
               l_d = data_in_one[i] ? (st_r.q[i] ^ cin[i])
                                    : st_r.q[i]; // R10 R11
               l_cout = data_in_two[i] ? (st_r.q[i] & cin[i])
                                       : (~st_r.q[i] & cin[i]); // R11
               l_lut = l_d;
            end
            default: begin
               // Packed use: register takes data four, table runs apart
               if (c[CFG_PACK_BIT]) begin
                  l_d = data_in_four[i]; // R5
               end
            end
         endcase
      end
      assign lut_res[i] = l_lut;
      assign d_next[i] = l_d;
      assign cin[i+1] = l_cout;
      // Cascade is an AND chain; a disabled cell passes its table alone
      assign casc[i+1] = c[CFG_CASC_BIT] ? (l_lut & casc[i])
                                         : l_lut; // R4 R8
   end

   logic [5:0] widx;
   assign widx = avs_address[7:2];

   always_comb begin
      st_nxt = st_r;
      // Register path, with clear over load over data
      if (grp_clk_en) begin
         if (grp_sync_clear) begin
            st_nxt.q = CELLS_RST; // R12 R13 R15
         end else if (grp_sync_load) begin
            st_nxt.q = data_in_three; // R12 R15
         end else begin
            st_nxt.q = d_next; // R10 R15
         end
      end
      st_nxt.comb = lut_res; // R9
      // Same signal to both areas; the pair gives 29 reachable cells
      for (int k = 0; k < NCELL; k++) begin
         st_nxt.area_a[k] = st_r.cfg[k][CFG_DRV_BIT] ? st_nxt.q[k]
                                                     : lut_res[k]; // R2 R14
      end
      st_nxt.area_b = st_nxt.area_a; // R14
      st_nxt.carry = cin[NCELL];
      st_nxt.casc = casc[NCELL];
      // Bus: one wait cycle, then the access completes
      st_nxt.waitreq = !((avs_read || avs_write) && st_r.waitreq);
      if (avs_read && st_r.waitreq) begin
         st_nxt.rdata = RDATA_RST;
         if (widx < IDX_CFG0 + 6'(NCELL)) begin
            st_nxt.rdata[CFG_W-1:0] = st_r.cfg[4'(widx)];
         end else if (widx == IDX_QSTAT) begin
            st_nxt.rdata[NCELL-1:0] = st_r.q;
         end else if (widx == IDX_CSTAT) begin
            st_nxt.rdata[NCELL-1:0] = st_r.comb;
         end else if (widx == IDX_CHAIN) begin
            st_nxt.rdata[1:0] = {st_r.casc, st_r.carry};
         end
      end
      // Writes only to config words; byte lanes honoured
      if (avs_write && !st_r.waitreq && widx < IDX_CFG0 + 6'(NCELL)) begin
         for (int b = 0; b < CFG_W; b++) begin
            if (avs_byteenable[b/8]) begin
               st_nxt.cfg[4'(widx)][b] = avs_writedata[b];
            end
         end
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         st_r.cfg <= {NCELL{CFG_RST}};
         st_r.q <= CELLS_RST;
         st_r.comb <= CELLS_RST;
         st_r.area_a <= CELLS_RST;
         st_r.area_b <= CELLS_RST;
         st_r.carry <= 1'b0;
         st_r.casc <= 1'b0;
         st_r.waitreq <= 1'b1;
         st_r.rdata <= RDATA_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign avs_readdata = st_r.rdata;
   assign avs_waitrequest = st_r.waitreq;
   assign cell_q = st_r.q;
   assign cell_comb = st_r.comb;
   assign local_area_a = st_r.area_a;
   assign local_area_b = st_r.area_b;
   assign carry_out = st_r.carry;
   assign cascade_out = st_r.casc;

   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   property p_clear;
      grp_clk_en && grp_sync_clear |=> cell_q == CELLS_RST;
   endproperty
   a_clear: assert property (p_clear) // R12
      else $error("group clear did not zero all cells");

   property p_load;
      grp_clk_en && !grp_sync_clear && grp_sync_load
         |=> cell_q == $past(data_in_three);
   endproperty
   a_load: assert property (p_load) // R15
      else $error("group load did not take data three");

   property p_hold;
      !grp_clk_en |=> $stable(cell_q);
   endproperty
   a_hold: assert property (p_hold) // R10
      else $error("cell register moved without clock enable");

   property p_count;
      grp_clk_en && !grp_sync_clear && !grp_sync_load && carry_in &&
      data_in_one[0] && st_r.cfg[0][CFG_MODE_LSB +: 2] == MODE_COUNT
         |=> cell_q[0] != $past(cell_q[0]);
   endproperty
   a_count: assert property (p_count) // R11
      else $error("enabled counter bit did not toggle");

   property p_adder;
      st_r.cfg[0][CFG_MODE_LSB +: 2] == MODE_ARITH &&
      st_r.cfg[0][15:0] == ADDER_MASK
         |=> cell_comb[0] ==
             $past(data_in_one[0] ^ data_in_two[0] ^ carry_in);
   endproperty
   a_adder: assert property (p_adder) // R7
      else $error("adder cell sum is wrong");

   property p_areas;
      local_area_a == local_area_b;
   endproperty
   a_areas: assert property (p_areas) // R14
      else $error("local areas disagree");

   property p_drive_reg;
      $past(st_r.cfg[0][CFG_DRV_BIT]) |-> local_area_a[0] == cell_q[0];
   endproperty
   a_drive_reg: assert property (p_drive_reg) // R9
      else $error("registered drive does not match cell register");

   property p_bus_ack;
      (avs_read || avs_write) && avs_waitrequest
         |=> !avs_waitrequest ##1 avs_waitrequest;
   endproperty
   a_bus_ack: assert property (p_bus_ack)
      else $error("bus answer not one cycle after request");

   property p_readback;
      avs_read && !avs_waitrequest && $past(widx) == IDX_QSTAT &&
      $past(avs_read)
         |-> avs_readdata[NCELL-1:0] == $past(cell_q);
   endproperty
   a_readback: assert property (p_readback)
      else $error("status read does not show cell registers");

   property p_wait_pulse;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_wait_pulse: assert property (p_wait_pulse)
      else $error("waitrequest stayed low for more than one cycle");

   // Reads outside the map return zero
   property p_unmapped;
      avs_read && avs_waitrequest && widx > IDX_CHAIN
         |=> avs_readdata == RDATA_RST;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read returned nonzero data");

   property p_chain_read;
      avs_read && avs_waitrequest && widx == IDX_CHAIN
         |=> avs_readdata[1:0] == $past({cascade_out, carry_out});
   endproperty
   a_chain_read: assert property (p_chain_read) // R4
      else $error("chain status read does not show chain ends");

   property p_comb_read;
      avs_read && avs_waitrequest && widx == IDX_CSTAT
         |=> avs_readdata[NCELL-1:0] == $past(cell_comb);
   endproperty
   a_comb_read: assert property (p_comb_read) // R9
      else $error("table status read does not show table results");

   // Cell 0 carry-out is the majority of its three inputs as an adder
   property p_carry_adder;
      st_r.cfg[0][CFG_MODE_LSB +: 2] == MODE_ARITH &&
      st_r.cfg[0][15:0] == ADDER_MASK
         |-> cin[1] == ((data_in_one[0] & data_in_two[0]) |
                        (carry_in & (data_in_one[0] ^ data_in_two[0])));
   endproperty
   a_carry_adder: assert property (p_carry_adder) // R6
      else $error("adder cell carry is wrong");

   property p_carry_normal;
      st_r.cfg[0][CFG_MODE_LSB +: 2] == MODE_NORMAL
         |-> cin[1] == carry_in;
   endproperty
   a_carry_normal: assert property (p_carry_normal) // R3
      else $error("normal cell does not pass the carry");

   property p_table;
      st_r.cfg[0][CFG_MODE_LSB +: 2] == MODE_NORMAL &&
      !st_r.cfg[0][CFG_CSEL_BIT]
         |=> cell_comb[0] == $past(st_r.cfg[0][{data_in_four[0],
             data_in_three[0], data_in_two[0], data_in_one[0]}]);
   endproperty
   a_table: assert property (p_table) // R3
      else $error("normal cell table result is wrong");

   property p_pack;
      st_r.cfg[0][CFG_MODE_LSB +: 2] == MODE_NORMAL &&
      st_r.cfg[0][CFG_PACK_BIT] && grp_clk_en && !grp_sync_clear &&
      !grp_sync_load |=> cell_q[0] == $past(data_in_four[0]);
   endproperty
   a_pack: assert property (p_pack) // R5
      else $error("packed register did not take data four");

   property p_area_lut;
      !$past(st_r.cfg[0][CFG_DRV_BIT]) |-> local_area_a[0] == cell_comb[0];
   endproperty
   a_area_lut: assert property (p_area_lut) // R2
      else $error("table drive does not match table result");

   // Up carries on ones, down borrows on zeros
   property p_count_carry;
      st_r.cfg[0][CFG_MODE_LSB +: 2] == MODE_COUNT && data_in_two[0]
         |-> cin[1] == (cell_q[0] && carry_in);
   endproperty
   a_count_carry: assert property (p_count_carry) // R11
      else $error("up counter carry is wrong");

   property p_borrow;
      st_r.cfg[0][CFG_MODE_LSB +: 2] == MODE_COUNT && !data_in_two[0]
         |-> cin[1] == (!cell_q[0] && carry_in);
   endproperty
   a_borrow: assert property (p_borrow) // R11
      else $error("down counter borrow is wrong");

endmodule

// ==== test_lcm_group.sv ====
// Self-checking bench for the logic array group
`timescale 1ns/1ps
module test_lcm_group;
   import lcm_pkg::*;
   logic mclk, reset, avs_read, avs_write, avs_waitrequest;
   logic [7:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [3:0] avs_byteenable;
   logic grp_clk_en, grp_sync_clear, grp_sync_load, carry_in, cascade_in;
   logic carry_out, cascade_out;
   logic [NCELL-1:0] data_in_one, data_in_two, data_in_three, data_in_four;
   logic [NCELL-1:0] cell_q, cell_comb, local_area_a, local_area_b;
   logic [10:0] sum;
   int mismatches, checked;
   lcm_group lcm_group_inst (.mclk(mclk), .reset(reset),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .grp_clk_en(grp_clk_en),
      .grp_sync_clear(grp_sync_clear), .grp_sync_load(grp_sync_load),
      .carry_in(carry_in), .cascade_in(cascade_in),
      .data_in_one(data_in_one), .data_in_two(data_in_two),
      .data_in_three(data_in_three), .data_in_four(data_in_four),
      .cell_q(cell_q), .cell_comb(cell_comb), .local_area_a(local_area_a),
      .local_area_b(local_area_b), .carry_out(carry_out),
      .cascade_out(cascade_out));
   task report_and_stop;
      $display("Checks %0d, mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // Request held until waitrequest is seen low at a rising edge
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] be);
      int n;
      n = 0;
      @(posedge mclk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      avs_byteenable <= be;
      do begin
         @(posedge mclk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) mismatches++;
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task cfg_all(input logic [31:0] v);
      for (int i = 0; i < NCELL; i++) bus(1'b1, 8'(i * 4), v, 4'hF);
   endtask
   task drive(input logic [9:0] a, b, c, d);
      data_in_one <= a;
      data_in_two <= b;
      data_in_three <= c;
      data_in_four <= d;
   endtask
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      #200000;
      mismatches++;
      report_and_stop();
   end
   initial begin
      reset = 1'b1;
      {avs_read, avs_write, grp_clk_en, grp_sync_clear, grp_sync_load} = '0;
      avs_address = 8'h00;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'h0;
      carry_in = 1'b0;
      cascade_in = 1'b1;
      {data_in_one, data_in_two, data_in_three, data_in_four} = '0;
      tick(5);
      reset <= 1'b0;
      chk("idle wait", 32'h1, {31'h0, avs_waitrequest});
      bus(1'b0, 8'h00, 32'h0, 4'hF);
      chk("cfg0 reset", 32'h0, rd);
      bus(1'b1, 8'h00, 32'h003FFFFF, 4'h1);
      bus(1'b0, 8'h00, 32'h0, 4'hF);
      chk("lane0 only", 32'h000000FF, rd);
      bus(1'b1, 8'h3C, 32'hFFFFFFFF, 4'hF);
      bus(1'b0, 8'h3C, 32'h0, 4'hF);
      chk("unmapped", 32'h0, rd);
      // Counter: enable and up from data inputs one and two
      cfg_all(32'h00020000);
      carry_in <= 1'b1;
      drive(10'h3FF, 10'h3FF, 10'h000, 10'h000);
      grp_sync_clear <= 1'b1;
      grp_clk_en <= 1'b1;
      tick(1);
      grp_sync_clear <= 1'b0;
      tick(5);
      grp_clk_en <= 1'b0;
      tick(2);
      chk("count up", 32'd5, 32'(cell_q));
      bus(1'b0, 8'h28, 32'h0, 4'hF);
      chk("q status", 32'd5, rd);
      drive(10'h3FF, 10'h000, 10'h000, 10'h000);
      grp_clk_en <= 1'b1;
      tick(7);
      grp_clk_en <= 1'b0;
      tick(2);
      chk("count down wrap", 32'h3FE, 32'(cell_q));
      drive(10'h3FF, 10'h3FF, 10'h2A5, 10'h000);
      grp_sync_load <= 1'b1;
      grp_clk_en <= 1'b1;
      tick(1);
      grp_sync_load <= 1'b0;
      grp_clk_en <= 1'b0;
      tick(2);
      chk("load over count", 32'h2A5, 32'(cell_q));
      grp_sync_clear <= 1'b1;
      tick(3);
      chk("clear needs enable", 32'h2A5, 32'(cell_q));
      grp_sync_load <= 1'b1;
      grp_clk_en <= 1'b1;
      tick(1);
      {grp_sync_clear, grp_sync_load, grp_clk_en} <= 3'b000;
      tick(2);
      chk("clear over load", 32'h0, 32'(cell_q));
      // Arithmetic: full adder across the carry chain
      cfg_all({10'h0, 6'h11, ADDER_MASK});
      grp_clk_en <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         sum = (k == 0) ? 11'h400 : (k == 1) ? 11'h400 :
               (k == 2) ? 11'h214 : 11'h3FF;
         carry_in <= (k == 1 || k == 2);
         drive(k == 0 ? 10'h3FF : k == 1 ? 10'h2AA :
               k == 2 ? 10'h123 : 10'h155,
               k == 0 ? 10'h001 : k == 1 ? 10'h155 :
               k == 2 ? 10'h0F0 : 10'h2AA, 10'h000, 10'h000);
         tick(4);
         chk("sum comb", 32'(sum[9:0]), 32'(cell_comb));
         chk("sum reg", 32'(sum[9:0]), 32'(cell_q));
         chk("carry out", 32'(sum[10]), 32'(carry_out));
         chk("arith cascade", 32'(&sum[9:0]), 32'(cascade_out));
      end
      // Normal: AND table, packed register, cascade AND chain
      cfg_all(32'h00188000);
      carry_in <= 1'b1;
      drive(10'h3F0, 10'h3FF, 10'h3FF, 10'h35A);
      tick(4);
      chk("and table", 32'h350, 32'(cell_comb));
      chk("packed reg", 32'h35A, 32'(cell_q));
      chk("area a", 32'h350, 32'(local_area_a));
      chk("area b", 32'h350, 32'(local_area_b));
      chk("chain", 32'h1, {30'h0, cascade_out, carry_out});
      bus(1'b0, 8'h2C, 32'h0, 4'hF);
      chk("comb status", 32'h350, rd);
      cfg_all(32'h001C8000);
      drive(10'h3FF, 10'h3FF, 10'h000, 10'h3FF);
      tick(4);
      chk("carry select", 32'h3FF, 32'(cell_comb));
      bus(1'b0, 8'h30, 32'h0, 4'hF);
      chk("chain status", 32'h3, rd);
      cascade_in <= 1'b0;
      tick(4);
      chk("cascade in low", 32'h0, 32'(cascade_out));
      // Mid-run reset returns cells and configs to their idle values
      reset <= 1'b1;
      tick(2);
      reset <= 1'b0;
      chk("reset q", 32'h0, 32'(cell_q));
      chk("reset wait", 32'h1, {31'h0, avs_waitrequest});
      bus(1'b0, 8'h00, 32'h0, 4'hF);
      chk("reset cfg", 32'h0, rd);
      report_and_stop();
   end
endmodule
